// *** hw/pid_pkg.sv ***
package pid_pkg;

  localparam int PARCEL_W         = 16;
  localparam int WORD_W           = 64;
  localparam int PARCELS_PER_WORD = 4;
  localparam int INST_W           = 48;
  localparam int MASK_W           = 64;
  localparam int ELEM_IDX_W       = 7;

  // First-parcel field positions, numbered from bit 0 upward
  localparam int G_MSB = 15;
  localparam int G_LSB = 12;
  localparam int H_MSB = 11;
  localparam int H_LSB = 9;
  localparam int I_MSB = 8;
  localparam int I_LSB = 6;
  localparam int J_MSB = 5;
  localparam int J_LSB = 3;
  localparam int K_MSB = 2;
  localparam int K_LSB = 0;
  localparam int I_TOP = 8;

  // Parcel counts of the three instruction lengths
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Opcode classes that pick the length
  localparam logic [6:0] OP_BRANCH_LO = 7'h06;
  localparam logic [6:0] OP_BRANCH_HI = 7'h0f;
  localparam logic [6:0] OP_IMM_A     = 7'h10;
  localparam logic [6:0] OP_IMM_A_ALT = 7'h11;
  localparam logic [6:0] OP_IMM_S     = 7'h20;
  localparam logic [6:0] OP_IMM_S_ALT = 7'h21;
  localparam logic [3:0] OP_MEM_LO    = 4'h8;
  localparam logic [3:0] OP_MEM_HI    = 4'hb;

  typedef enum logic [2:0] {
    FMT_ONE,
    FMT_BRANCH2,
    FMT_IMM3,
    FMT_BRANCH3,
    FMT_MEMREF3
  } pid_fmt_e;

endpackage

// *** hw/pid_dec_if.sv ***
`timescale 1ns/1ns
interface pid_dec_if;
  logic [47:0]      inst;
  logic             legacy_mode;
  pid_pkg::pid_fmt_e fmt;
  logic [1:0]       len;
  logic [6:0]       combined_opcode;
  logic [3:0]       opcode4;
  logic [2:0]       res_d;
  logic [2:0]       opa_d;
  logic [2:0]       opb_d;
  logic [5:0]       jk_value;
  logic [23:0]      addr24;
  logic [31:0]      wide_immediate_value;
  logic [7:0]       branch_opcode8;
  logic             result_field_top_bit;
  logic [2:0]       index_d;

  modport decoder (
    input  inst,
    input  legacy_mode,
    output fmt,
    output len,
    output combined_opcode,
    output opcode4,
    output res_d,
    output opa_d,
    output opb_d,
    output jk_value,
    output addr24,
    output wide_immediate_value,
    output branch_opcode8,
    output result_field_top_bit,
    output index_d
  );

  modport user (
    output inst,
    output legacy_mode,
    input  fmt,
    input  len,
    input  combined_opcode,
    input  opcode4,
    input  res_d,
    input  opa_d,
    input  opb_d,
    input  jk_value,
    input  addr24,
    input  wide_immediate_value,
    input  branch_opcode8,
    input  result_field_top_bit,
    input  index_d
  );
endinterface

// *** hw/pid_field_dec.sv ***
`timescale 1ns/1ns
module pid_field_dec (
  pid_dec_if.decoder d
);
  logic [15:0] p1;
  logic [15:0] p2;
  logic [15:0] p3;
  logic [3:0]  g;
  logic [2:0]  h;
  logic [2:0]  i;
  logic [2:0]  j;
  logic [2:0]  k;
  logic [6:0]  op7;

  assign p1 = d.inst[47:32];
  assign p2 = d.inst[31:16];
  assign p3 = d.inst[15:0];
  // Five fields in the first parcel, later parcels whole
  assign g  = p1[pid_pkg::G_MSB:pid_pkg::G_LSB];
  assign h  = p1[pid_pkg::H_MSB:pid_pkg::H_LSB];
  assign i  = p1[pid_pkg::I_MSB:pid_pkg::I_LSB];
  assign j  = p1[pid_pkg::J_MSB:pid_pkg::J_LSB];
  assign k  = p1[pid_pkg::K_MSB:pid_pkg::K_LSB];
  assign op7 = {g, h};

  assign d.combined_opcode      = op7;
  assign d.opcode4              = g;
  assign d.index_d              = h;
  assign d.res_d                = i;
  assign d.opa_d                = j;
  assign d.opb_d                = k;
  assign d.jk_value             = {j, k};
  assign d.result_field_top_bit = p1[pid_pkg::I_TOP];
  // Top result bit is zero in this form, so the address drops it
  assign d.addr24               = {i[1:0], j, k, p2};
  // Second parcel holds the low half, third the high half
  assign d.wide_immediate_value = {p3, p2};
  assign d.branch_opcode8       = {op7, i[2]};

  always_comb
  begin
    d.fmt = pid_pkg::FMT_ONE;
    d.len = pid_pkg::LEN_ONE;
    if (g >= pid_pkg::OP_MEM_LO && g <= pid_pkg::OP_MEM_HI)
    begin
      d.fmt = pid_pkg::FMT_MEMREF3;
      d.len = pid_pkg::LEN_THREE;
    end
    else if (op7 >= pid_pkg::OP_BRANCH_LO && op7 <= pid_pkg::OP_BRANCH_HI)
    begin
      if (d.legacy_mode)
      begin
        d.fmt = pid_pkg::FMT_BRANCH2;
        d.len = pid_pkg::LEN_TWO;
      end
      else
      begin
        d.fmt = pid_pkg::FMT_BRANCH3;
        d.len = pid_pkg::LEN_THREE;
      end
    end
    else if (op7 == pid_pkg::OP_IMM_A || op7 == pid_pkg::OP_IMM_A_ALT ||
             op7 == pid_pkg::OP_IMM_S || op7 == pid_pkg::OP_IMM_S_ALT)
    begin
      d.fmt = pid_pkg::FMT_IMM3;
      d.len = pid_pkg::LEN_THREE;
    end
  end
endmodule // pid_field_dec

// *** hw/pid_decoder.sv ***
`timescale 1ns/1ns
// How it works
// - Every instruction is one, two or three 16-bit parcels long and nothing else.
// - A 64-bit word carries four parcels, parcel 0 in the top sixteen bits and parcel 3 last.
// - Decoding may begin at any parcel, and parcel 3 of a word runs on into parcel 0 of the next.
// - The first parcel splits into five fields while later parcels are each one field.
// - In the discrete form the two leading fields are the opcode, the third the result and the last two the operands.
// - In the combined one-parcel form the two trailing fields read as one 6-bit value.
// - The legacy two-parcel branch has a 7-bit opcode and a 24-bit parcel address whose top result bit is zero.
// - The three-parcel immediate has a 7-bit opcode, a 3-bit result and a 32-bit constant from parcels two and three.
// - The native three-parcel branch takes its address from parcels two and three and its opcode may include the top result bit.
// - The three-parcel memory reference has a 4-bit opcode, a 3-bit index and a 3-bit data register with a 32-bit address.
// - The low mask register covers elements 0 to 63 and the high mask register elements 64 to 127.
// - Bits are numbered from the least significant upward, each number being its weight.
module pid_decoder #(
  parameter int WORDS_HELD = 2
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              legacy_mode,
  input  wire logic              redirect,
  input  wire logic [1:0]        redirect_parcel,
  input  wire logic              word_valid,
  input  wire logic [63:0]       word_data,
  output logic                   word_ready,
  output logic                   inst_valid,
  input  wire logic              inst_ready,
  output pid_pkg::pid_fmt_e      inst_fmt,
  output logic [1:0]             inst_len,
  output logic [6:0]             combined_opcode,
  output logic [3:0]             mem_opcode,
  output logic [2:0]             result_reg,
  output logic [2:0]             operand_a_reg,
  output logic [2:0]             operand_b_reg,
  output logic [5:0]             jk_value,
  output logic [23:0]            branch_addr,
  output logic [31:0]            wide_immediate_value,
  output logic [7:0]             branch_opcode,
  output logic                   result_field_top_bit,
  output logic [2:0]             index_reg,
  input  wire logic [63:0]       mask_low_register,
  input  wire logic [63:0]       mask_high_register,
  input  wire logic [6:0]        elem_idx,
  output logic                   elem_mask_bit
);

  // buf0 holds the parcel at ptr, buf1 the word after it
  typedef struct packed {
    logic [63:0]       buf0;
    logic [63:0]       buf1;
    logic [1:0]        nwords;
    logic [1:0]        ptr;
    logic              out_valid;
    pid_pkg::pid_fmt_e out_fmt;
    logic [1:0]        out_len;
    logic [6:0]        out_op7;
    logic [3:0]        out_op4;
    logic [2:0]        out_i;
    logic [2:0]        out_j;
    logic [2:0]        out_k;
    logic [5:0]        out_jk;
    logic [23:0]       out_addr;
    logic [31:0]       out_imm;
    logic [7:0]        out_bop;
    logic              out_top;
    logic [2:0]        out_idx;
    logic              elem_bit;
  } pid_state_s;

  pid_state_s st_r;
  pid_state_s st_nxt;
  pid_dec_if  dec ();

  logic [127:0] window_w;
  logic [2:0]   ptr3;
  logic [15:0]  par_first;
  logic [15:0]  par_second;
  logic [15:0]  par_third;
  logic [3:0]   need;
  logic [3:0]   avail;
  logic         fits;
  logic         slot_free;
  logic         window_full;
  logic         can_issue;
  logic         take_word;

  // Parcel n of the two-word window; parcel 0 of a word is its top sixteen bits
  function automatic logic [15:0] pid_parcel(input logic [127:0] w, input logic [2:0] idx);
    pid_parcel = w[(3'd7 - idx) * 16 +: 16];
  endfunction

  // Element numbers below 64 select the low register, the rest the high one
  function automatic logic pid_mask_pick(input logic [63:0] lo,
                                         input logic [63:0] hi,
                                         input logic [6:0]  elem);
    logic [5:0] bitpos;
    bitpos = elem[5:0];
    if (elem[6])
    begin
      pid_mask_pick = hi[bitpos];
    end
    else
    begin
      pid_mask_pick = lo[bitpos];
    end
  endfunction

  assign window_w = {st_r.buf0, st_r.buf1};
  assign ptr3     = {1'b0, st_r.ptr};

  // Three parcels are always presented; unused ones are ignored by length.
  // Parcels past the instruction may be stale, so fields built from them
  // mean something only for the formats that own those parcels.
  assign par_first  = pid_parcel(window_w, ptr3);
  assign par_second = pid_parcel(window_w, ptr3 + 3'd1);
  assign par_third  = pid_parcel(window_w, ptr3 + 3'd2);
  assign dec.inst   = {par_first, par_second, par_third};
  assign dec.legacy_mode = legacy_mode;

  pid_field_dec u_dec (
    .d (dec.decoder)
  );

  // Four parcels per word held; need is one past the instruction's last parcel
  assign need      = {2'b00, st_r.ptr} + {2'b00, dec.len};
  assign avail     = {st_r.nwords, 2'b00};
  // Issue only once every parcel of the instruction has arrived
  assign fits      = (need <= avail);
  assign slot_free = !st_r.out_valid || inst_ready;
  assign can_issue = ce && !redirect && fits && slot_free;
  // A full window stalls fetch for a cycle even if a shift is due; keeps the path short
  assign window_full = (st_r.nwords == 2'(WORDS_HELD));
  assign word_ready  = ce && !redirect && !window_full;
  assign take_word  = word_ready && word_valid;

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.out_valid && inst_ready)
    begin
      st_nxt.out_valid = 1'b0;
    end
    if (can_issue)
    begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_fmt   = dec.fmt;
      st_nxt.out_len   = dec.len;
      st_nxt.out_op7   = dec.combined_opcode;
      st_nxt.out_op4   = dec.opcode4;
      st_nxt.out_i     = dec.res_d;
      st_nxt.out_j     = dec.opa_d;
      st_nxt.out_k     = dec.opb_d;
      st_nxt.out_jk    = dec.jk_value;
      st_nxt.out_addr  = dec.addr24;
      st_nxt.out_imm   = dec.wide_immediate_value;
      st_nxt.out_bop   = dec.branch_opcode8;
      st_nxt.out_top   = dec.result_field_top_bit;
      st_nxt.out_idx   = dec.index_d;
      st_nxt.ptr       = need[1:0];
      // Past parcel 3 the next word becomes the current one
      if (need[2])
      begin
        st_nxt.buf0   = st_r.buf1;
        st_nxt.nwords = st_r.nwords - 2'd1;
      end
    end
    if (take_word)
    begin
      if (st_nxt.nwords == 2'd0)
      begin
        st_nxt.buf0 = word_data;
      end
      else
      begin
        st_nxt.buf1 = word_data;
      end
      st_nxt.nwords = st_nxt.nwords + 2'd1;
    end
    // Branch target: next word fetched is the target word.
    // Placed last; an issue or a word taken cannot happen in this cycle, as both are held off while redirect is high.
    if (ce && redirect)
    begin
      st_nxt.nwords    = 2'd0;
      st_nxt.ptr       = redirect_parcel;
      st_nxt.out_valid = 1'b0;
    end
    st_nxt.elem_bit = pid_mask_pick(mask_low_register, mask_high_register, elem_idx);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      // Buffers need no clearing once nwords is zero, but a full clear costs little
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // Every field is shown for every format; the consumer picks by inst_fmt
  assign inst_valid           = st_r.out_valid;
  assign inst_fmt             = st_r.out_fmt;
  assign inst_len             = st_r.out_len;
  assign combined_opcode      = st_r.out_op7;
  assign mem_opcode           = st_r.out_op4;
  assign result_reg           = st_r.out_i;
  assign operand_a_reg        = st_r.out_j;
  assign operand_b_reg        = st_r.out_k;
  assign jk_value             = st_r.out_jk;
  assign branch_addr          = st_r.out_addr;
  assign wide_immediate_value = st_r.out_imm;
  assign branch_opcode        = st_r.out_bop;
  assign result_field_top_bit = st_r.out_top;
  assign index_reg            = st_r.out_idx;
  assign elem_mask_bit        = st_r.elem_bit;

endmodule // pid_decoder

// *** tb/pid_decoder_props.sv ***
`timescale 1ns/1ns
module pid_decoder_props (
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic              ce,
  input wire logic              redirect,
  input wire logic              word_ready,
  input wire logic              inst_valid,
  input wire logic              inst_ready,
  input pid_pkg::pid_fmt_e      inst_fmt,
  input wire logic [1:0]        inst_len,
  input wire logic [6:0]        combined_opcode,
  input wire logic [3:0]        mem_opcode,
  input wire logic [2:0]        index_reg,
  input wire logic [2:0]        result_reg,
  input wire logic [2:0]        operand_a_reg,
  input wire logic [2:0]        operand_b_reg,
  input wire logic [5:0]        jk_value,
  input wire logic [23:0]       branch_addr,
  input wire logic [31:0]       wide_immediate_value,
  input wire logic [7:0]        branch_opcode,
  input wire logic              result_field_top_bit,
  input wire logic [63:0]       mask_low_register,
  input wire logic [63:0]       mask_high_register,
  input wire logic [6:0]        elem_idx,
  input wire logic              elem_mask_bit
);
  wire [127:0] mask_all = {mask_high_register, mask_low_register};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  opcode_split_a: assert property (
    inst_valid |-> combined_opcode == {mem_opcode, index_reg}) else $error("opcode split wrong");
  jk_join_a: assert property (
    inst_valid |-> jk_value == {operand_a_reg, operand_b_reg}) else $error("jk join wrong");
  top_bit_a: assert property (
    inst_valid |-> result_field_top_bit == result_reg[2]) else $error("top bit wrong");
  branch_op_a: assert property (
    inst_valid |-> branch_opcode == {combined_opcode, result_reg[2]})
    else $error("branch opcode wrong");
  branch_addr_a: assert property (
    inst_valid |-> branch_addr[23:16] == {result_reg[1:0], operand_a_reg, operand_b_reg})
    else $error("branch address top wrong");
  imm_low_a: assert property (
    inst_valid |-> wide_immediate_value[15:0] == branch_addr[15:0])
    else $error("immediate low half wrong");
  len_fmt_a: assert property (
    inst_valid |-> inst_len == (inst_fmt == pid_pkg::FMT_ONE ? 2'h1 :
                   inst_fmt == pid_pkg::FMT_BRANCH2 ? 2'h2 : 2'h3)) else $error("length wrong");
  mask_bit_a: assert property (
    ce |=> elem_mask_bit == $past(mask_all[elem_idx])) else $error("mask bit wrong");
  inst_hold_a: assert property (
    inst_valid && !inst_ready && !redirect |=> inst_valid && $stable(combined_opcode)
    && $stable(wide_immediate_value)) else $error("instruction not held");
  redirect_flush_a: assert property (
    ce && redirect |=> !inst_valid) else $error("redirect did not flush");
  fetch_block_a: assert property (
    redirect || !ce |-> !word_ready) else $error("word taken during redirect");
  imm_c: cover property (inst_valid && inst_fmt == pid_pkg::FMT_IMM3);
  br2_c: cover property (inst_valid && inst_fmt == pid_pkg::FMT_BRANCH2);
  br3_c: cover property (inst_valid && inst_fmt == pid_pkg::FMT_BRANCH3);
  mem_c: cover property (inst_valid && inst_fmt == pid_pkg::FMT_MEMREF3);
endmodule // pid_decoder_props

// *** tb/pid_fetch_model.sv ***
`timescale 1ns/1ns
module pid_fetch_model (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          restart,
  input  wire logic [1023:0] prog,
  input  wire logic          word_ready,
  output logic               word_valid,
  output logic [63:0]        word_data
);
  logic [4:0]  idx;
  logic        vld;
  logic [63:0] last = 64'h0;
  // An idle bus shows the inverse of the last word so stale data never matches
  assign word_valid = vld && (idx < 5'h10);
  assign word_data  = word_valid ? prog[1023 - 64 * idx -: 64] : ~last;
  always @(posedge ref_clk)
  begin
    if (!rstn || restart)
    begin
      idx <= #1 5'h0;
      vld <= #1 1'b0;
    end
    else
    begin
      if (word_valid && word_ready)
      begin
        idx  <= #1 idx + 5'h1;
        last <= #1 word_data;
      end
      // Offer is held until taken; random gaps stall the fetch side
      if (!vld || word_ready)
        vld <= #1 ($urandom_range(3) != 0);
    end
  end
endmodule // pid_fetch_model

// *** tb/pid_decoder_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
bind pid_decoder pid_decoder_props u_pid_decoder_props (.*);
module pid_decoder_tb;
  logic ref_clk = 0, rstn = 0, ce = 1, legacy_mode = 1, redirect = 0, inst_ready = 0;
  logic [1:0] redirect_parcel = 2'h0, inst_len;
  logic word_valid, word_ready, inst_valid, result_field_top_bit, elem_mask_bit;
  logic [63:0] word_data, mask_low_register = 64'h0, mask_high_register = 64'h0;
  logic [6:0] elem_idx = 7'h0, combined_opcode;
  logic [3:0] mem_opcode;
  logic [2:0] result_reg, operand_a_reg, operand_b_reg, index_reg;
  logic [5:0] jk_value;
  logic [23:0] branch_addr;
  logic [31:0] wide_immediate_value;
  logic [7:0] branch_opcode;
  pid_pkg::pid_fmt_e inst_fmt;
  logic [1023:0] prog;
  logic [4:0] c;
  logic [15:0] p1;
  logic exp_mask, mask_ok = 0;
  int pos, n_exp, n_done, bad_count = 0, tests_run = 0;
  pid_decoder u_pid_decoder (.*);
  pid_fetch_model u_pid_fetch_model (.ref_clk(ref_clk), .rstn(rstn), .restart(redirect),
    .prog(prog), .word_ready(word_ready), .word_valid(word_valid), .word_data(word_data));
  always #2 ref_clk = ~ref_clk;
  function logic [15:0] par(input int i);
    return i < 64 ? prog[1023 - 16 * i -: 16] : 16'h0;
  endfunction
  function logic [4:0] cls(input logic [15:0] p, input logic lm);
    logic [6:0] op7;
    op7 = p[15:9];
    if (p[15:12] >= pid_pkg::OP_MEM_LO && p[15:12] <= pid_pkg::OP_MEM_HI)
      return {pid_pkg::FMT_MEMREF3, 2'h3};
    if (op7 >= pid_pkg::OP_BRANCH_LO && op7 <= pid_pkg::OP_BRANCH_HI)
      return lm ? {pid_pkg::FMT_BRANCH2, 2'h2} : {pid_pkg::FMT_BRANCH3, 2'h3};
    if (op7 == pid_pkg::OP_IMM_A || op7 == pid_pkg::OP_IMM_A_ALT || op7 == pid_pkg::OP_IMM_S
        || op7 == pid_pkg::OP_IMM_S_ALT)
      return {pid_pkg::FMT_IMM3, 2'h3};
    return {pid_pkg::FMT_ONE, 2'h1};
  endfunction
  task build(input int start);
    logic [15:0] q;
    logic [4:0] k;
    int p;
    for (int w = 0; w < 32; w++)
      prog[32 * w +: 32] = $urandom;
    p = start;
    pos = start;
    n_exp = 0;
    n_done = 0;
    while (p < 64)
    begin
      q = 16'($urandom);
      // Fixed head: three short ones, then a long one on parcel 3, a branch on 6
      if (p - start < 3) q[15:12] = 4'h7;
      else if (p - start == 3) q[15:9] = pid_pkg::OP_IMM_A;
      else if (p - start == 6) q[15:9] = pid_pkg::OP_BRANCH_LO;
      k = cls(q, legacy_mode);
      if (k[4:2] == pid_pkg::FMT_BRANCH2) q[8] = 1'b0;
      if (p + k[1:0] > 64) break;
      prog[1023 - 16 * p -: 16] = q;
      p += k[1:0];
      n_exp++;
    end
    // A three-parcel head that cannot complete keeps the tail from issuing
    if (p < 64) prog[1023 - 16 * p -: 4] = 4'h8;
  endtask
  always @(posedge ref_clk)
  begin
    inst_ready <= #1 ($urandom_range(3) != 0);
    ce <= #1 (!rstn || $urandom_range(7) != 0);
    mask_low_register <= #1 {$urandom, $urandom};
    mask_high_register <= #1 {$urandom, $urandom};
    elem_idx <= #1 7'($urandom);
    if (!rstn) mask_ok = 0;
    else if (ce)
    begin
      if (mask_ok) `CHK("elem_mask_bit", exp_mask, elem_mask_bit)
      exp_mask = (elem_idx < 7'h40) ? mask_low_register[6'(elem_idx)]
                                    : mask_high_register[6'(elem_idx - 7'h40)];
      mask_ok = 1;
      if (inst_valid && inst_ready)
      begin
        p1 = par(pos);
        c = cls(p1, legacy_mode);
        `CHK("inst_fmt", c[4:2], inst_fmt)
        `CHK("inst_len", c[1:0], inst_len)
        `CHK("combined_opcode", p1[15:9], combined_opcode)
        `CHK("mem_opcode", p1[15:12], mem_opcode)
        `CHK("index_reg", p1[11:9], index_reg)
        `CHK("result_reg", p1[8:6], result_reg)
        `CHK("operand_a_reg", p1[5:3], operand_a_reg)
        `CHK("operand_b_reg", p1[2:0], operand_b_reg)
        `CHK("jk_value", p1[5:0], jk_value)
        // Parcels beyond the instruction may not have arrived, so only owned ones are compared
        if (c[1:0] == 2'h1)
          `CHK("branch_addr_top", p1[7:0], branch_addr[23:16])
        else
          `CHK("branch_addr", {p1[7:0], par(pos + 1)}, branch_addr)
        if (c[1:0] == 2'h3)
          `CHK("wide_immediate_value", {par(pos + 2), par(pos + 1)}, wide_immediate_value)
        else if (c[1:0] == 2'h2)
          `CHK("wide_immediate_low", par(pos + 1), wide_immediate_value[15:0])
        `CHK("branch_opcode", p1[15:8], branch_opcode)
        `CHK("result_field_top_bit", p1[8], result_field_top_bit)
        pos += c[1:0];
        n_done++;
      end
    end
  end
  task conclude;
    $display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task drain;
    for (int k = 0; k < 4000 && n_done < n_exp; k++)
      @(posedge ref_clk);
    `CHK("issued count", n_exp, n_done)
  endtask
  initial
  begin
    #40000;
    bad_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(38200));
    build(0);
    repeat (10) @(posedge ref_clk);
    rstn <= #1 1'b1;
    drain();
    @(posedge ref_clk);
    legacy_mode <= #1 1'b0;
    @(posedge ref_clk);
    build(1);
    redirect <= #1 1'b1;
    redirect_parcel <= #1 2'h1;
    do @(posedge ref_clk); while (!ce);
    redirect <= #1 1'b0;
    drain();
    conclude();
  end
endmodule // pid_decoder_tb
